// ==== src/hqc_ctrl.sv ====
// host queue transmit/receive control and status, classic wishbone slave
// assumes a single 40 MHz clock; fabric inputs share it, the config pin does not
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "hqc_consts.svh"
module hqc_ctrl
    import hqc_pkg::*;
#(
    parameter int QUANTUM_CYC = `HQC_QUANTUM_CYC
)(
    input  wire logic         CLK,            // 40 MHz clock
    input  wire logic         RST_N,          // async reset, active low
    input  wire logic         CYC_I,          // wishbone cycle
    input  wire logic         STB_I,          // wishbone strobe
    input  wire logic         WE_I,           // wishbone write
    input  wire logic [5:0]   ADR_I,          // byte address
    input  wire logic [3:0]   SEL_I,          // byte lanes
    input  wire logic [31:0]  DAT_I,          // write data
    output logic      [31:0]  DAT_O,          // read data
    output logic              ACK_O,          // wishbone acknowledge
    input  wire logic         CONFIG_MEM_EN,  // config memory enable pin
    input  wire logic         CFG_WORD_VALID, // config word loaded, pulse
    input  wire logic [15:0]  CFG_WORD,       // config parameter word
    input  wire logic         SW_FLOW_EN,     // switch global flow control bit
    input  wire logic         RX_FIFO_THRESH, // receive fifo at threshold
    input  wire hqc_tx_evt_t  TX_EVT,         // transmit frame events
    input  wire logic         RX_START,       // receive frame begins, pulse
    input  wire hqc_rx_desc_t RX_DESC,        // received frame descriptor
    input  wire logic         PAUSE_RCVD,     // pause frame received, pulse
    input  wire logic [15:0]  PAUSE_QUANTA,   // pause time of that frame
    input  wire logic [47:0]  STATION_ADDR,   // own station address
    output logic              TX_RUN,         // transmit running
    output logic              TX_GO,          // a new frame may start
    output logic              TX_PAD,         // pad the frame now sent
    output logic              TX_CRC,         // append crc
    output logic              TX_PAUSE_SEND,  // send pause frames
    output logic              RX_RUN,         // receive running
    output logic              RX_ACCEPT,      // frame admitted, pulse
    output logic              RX_DROP,        // frame discarded, pulse
    output logic              RX_STRIP,       // strip crc from frames
    output logic              QM_RESET        // queue manager soft reset
);

    if (QUANTUM_CYC < 1 || QUANTUM_CYC > 65535)
    begin : g_chk
        $error("QUANTUM_CYC out of range");
    end

    logic [15:0] txctl;
    logic [15:0] rxctl;
    logic        grst;
    logic [4:0]  bank;
    logic        bus_width;
    logic        cfg_meta;
    logic        cfg_en;
    logic [5:0]  last_id;
    hqc_run_t    tx_state;
    hqc_run_t    rx_state;
    logic        tx_busy;
    logic        rx_busy;
    logic [15:0] pause_left;
    logic [15:0] quantum_cnt;
    logic        pause_hold;

    // bus decode
    logic        req;
    logic        wr;
    logic [3:0]  idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        lo_ok;

    assign req   = CYC_I && STB_I && !ACK_O;
    assign wr    = req && WE_I;
    assign idx   = ADR_I[5:2];
    assign wdata = DAT_I[15:0];
    // software reset leaves the bank select alone, so it is outside this path
    assign lo_ok = !grst;

    always_comb
    begin
        rdata = 16'h0000;
        if (idx == `HQC_IDX_BANKSEL)
        begin
            rdata = {11'h000, bank};
        end
        else if (bank == `HQC_BANK_SYS)
        begin
            case (idx)
                `HQC_IDX_GRST:   rdata = {15'h0000, grst};
                `HQC_IDX_BUSCFG: rdata = {15'h0000, bus_width};
                default:         rdata = 16'h0000;
            endcase
        end
        else if (bank == `HQC_BANK_QUEUE)
        begin
            case (idx)
                `HQC_IDX_TXCTL:  rdata = txctl;
                `HQC_IDX_TXSTAT: rdata = {10'h000, last_id};
                `HQC_IDX_RXCTL:  rdata = rxctl;
                default:         rdata = 16'h0000;
            endcase
        end
    end

    // one wait-free answer: ack the cycle after the request, unmapped reads zero
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ACK_O <= req;
            if (req && !WE_I)
            begin
                DAT_O <= {16'h0000, rdata};
            end
        end
    end

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (sel[0])
        begin
            v[7:0] = nw[7:0];
        end
        if (sel[1])
        begin
            v[15:8] = nw[15:8];
        end
        return v & mask;
    endfunction : merge

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bank <= `HQC_BANK_RESET;
        end
        else if (wr && idx == `HQC_IDX_BANKSEL && SEL_I[0])
        begin
            bank <= wdata[4:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            grst <= 1'b0;
        end
        else if (wr && bank == `HQC_BANK_SYS && idx == `HQC_IDX_GRST && SEL_I[0])
        begin
            grst <= wdata[0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            txctl <= `HQC_CTL_RESET;
            rxctl <= `HQC_CTL_RESET;
        end
        else if (!lo_ok)
        begin
            txctl <= `HQC_CTL_RESET;
            rxctl <= `HQC_CTL_RESET;
        end
        else if (wr && bank == `HQC_BANK_QUEUE)
        begin
            if (idx == `HQC_IDX_TXCTL)
            begin
                txctl <= merge(txctl, wdata, SEL_I, `HQC_TXCTL_MASK);
            end
            if (idx == `HQC_IDX_RXCTL)
            begin
                rxctl <= merge(rxctl, wdata, SEL_I, `HQC_RXCTL_MASK);
            end
        end
    end

    // config pin is asynchronous to CLK
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cfg_meta <= 1'b0;
            cfg_en   <= 1'b0;
        end
        else
        begin
            cfg_meta <= CONFIG_MEM_EN;
            cfg_en   <= cfg_meta;
        end
    end

    // without config memory the bit has no meaning; it reads zero then
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bus_width <= 1'b0;
        end
        else if (!cfg_en)
        begin
            bus_width <= 1'b0;
        end
        else if (CFG_WORD_VALID)
        begin
            bus_width <= CFG_WORD[0];
        end
    end

    // transmit run state
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_busy <= 1'b0;
            last_id <= 6'h00;
        end
        else
        begin
            if (TX_EVT.done)
            begin
                tx_busy <= 1'b0;
                last_id <= TX_EVT.id;
            end
            else if (TX_EVT.start)
            begin
                tx_busy <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_state <= HQC_STOPPED;
        end
        else
        begin
            case (tx_state)
                HQC_STOPPED:
                    if (txctl[`HQC_TX_RUN_BIT])
                    begin
                        tx_state <= HQC_RUNNING;
                    end
                HQC_RUNNING:
                    if (!txctl[`HQC_TX_RUN_BIT])
                    begin
                        tx_state <= (tx_busy && !TX_EVT.done) ? HQC_DRAINING : HQC_STOPPED;
                    end
                HQC_DRAINING:
                    if (TX_EVT.done || !tx_busy)
                    begin
                        tx_state <= HQC_STOPPED;
                    end
                default:
                    tx_state <= HQC_STOPPED;
            endcase
        end
    end

    // pause timer for honoured pause frames
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pause_left  <= 16'h0000;
            quantum_cnt <= 16'h0000;
        end
        else if (!lo_ok)
        begin
            pause_left  <= 16'h0000;
            quantum_cnt <= 16'h0000;
        end
        else if (PAUSE_RCVD && rxctl[`HQC_RX_PAUSE_BIT])
        begin
            pause_left  <= PAUSE_QUANTA;
            quantum_cnt <= 16'(QUANTUM_CYC - 1);
        end
        else if (pause_left != 16'h0000)
        begin
            if (quantum_cnt == 16'h0000)
            begin
                pause_left  <= pause_left - 16'h0001;
                quantum_cnt <= 16'(QUANTUM_CYC - 1);
            end
            else
            begin
                quantum_cnt <= quantum_cnt - 16'h0001;
            end
        end
    end

    assign pause_hold = (pause_left != 16'h0000);

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            TX_RUN        <= 1'b0;
            TX_GO         <= 1'b0;
            TX_PAD        <= 1'b0;
            TX_CRC        <= 1'b0;
            TX_PAUSE_SEND <= 1'b0;
            QM_RESET      <= 1'b0;
        end
        else
        begin
            TX_RUN        <= (tx_state != HQC_STOPPED);
            // stalled frames wait in the buffer while paused
            TX_GO         <= (tx_state == HQC_RUNNING) && txctl[`HQC_TX_RUN_BIT]
                             && !pause_hold;
            TX_CRC        <= txctl[`HQC_TX_CRC_BIT];
            TX_PAUSE_SEND <= txctl[`HQC_TX_PAUSE_BIT] && SW_FLOW_EN
                             && RX_FIFO_THRESH;
            QM_RESET      <= grst;
            if (TX_EVT.start)
            begin
                TX_PAD <= txctl[`HQC_TX_PAD_BIT] && TX_EVT.short_len;
            end
        end
    end

    // receive run state
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_busy <= 1'b0;
        end
        else if (RX_DESC.valid)
        begin
            rx_busy <= 1'b0;
        end
        else if (RX_START)
        begin
            rx_busy <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_state <= HQC_STOPPED;
        end
        else
        begin
            case (rx_state)
                HQC_STOPPED:
                    if (rxctl[`HQC_RX_RUN_BIT])
                    begin
                        rx_state <= HQC_RUNNING;
                    end
                HQC_RUNNING:
                    if (!rxctl[`HQC_RX_RUN_BIT])
                    begin
                        rx_state <= (rx_busy && !RX_DESC.valid) ? HQC_DRAINING : HQC_STOPPED;
                    end
                HQC_DRAINING:
                    if (RX_DESC.valid || !rx_busy)
                    begin
                        rx_state <= HQC_STOPPED;
                    end
                default:
                    rx_state <= HQC_STOPPED;
            endcase
        end
    end

    // address filters; first octet sits in dest[47:40], its lsb marks group
    logic is_bcast;
    logic is_mcast;
    logic addr_ok;
    logic crc_ok;

    assign is_bcast = (RX_DESC.dest == 48'hFFFF_FFFF_FFFF);
    assign is_mcast = RX_DESC.dest[40];
    assign addr_ok  = rxctl[`HQC_RX_PROMISC_BIT]
                    | (is_bcast & rxctl[`HQC_RX_BCAST_BIT])
                    | (is_mcast & rxctl[`HQC_RX_MCAST_BIT])
                    | (is_mcast & rxctl[`HQC_RX_HASH_BIT] & RX_DESC.hash_hit)
                    | (!is_mcast & rxctl[`HQC_RX_UCAST_BIT]
                       & (RX_DESC.dest == STATION_ADDR));
    assign crc_ok   = !RX_DESC.crc_err || rxctl[`HQC_RX_BADCRC_BIT];

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RX_RUN    <= 1'b0;
            RX_ACCEPT <= 1'b0;
            RX_DROP   <= 1'b0;
            RX_STRIP  <= 1'b0;
        end
        else
        begin
            RX_RUN    <= (rx_state != HQC_STOPPED);
            RX_STRIP  <= rxctl[`HQC_RX_STRIP_BIT];
            RX_ACCEPT <= RX_DESC.valid && (rx_state != HQC_STOPPED) && addr_ok && crc_ok;
            RX_DROP   <= RX_DESC.valid && !((rx_state != HQC_STOPPED) && addr_ok && crc_ok);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_ack_one;
        req |=> ACK_O ##1 !ACK_O;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not single cycle");

    property p_reserved_bank;
        (req && !WE_I && idx != `HQC_IDX_BANKSEL && bank > `HQC_BANK_SYS
         && bank < `HQC_BANK_QUEUE) |=> (DAT_O == 32'h0000_0000);
    endproperty
    a_reserved_bank: assert property (p_reserved_bank) else $error("reserved bank read");

    property p_bus_width;
        (cfg_en && CFG_WORD_VALID) |=> (bus_width == $past(CFG_WORD[0]));
    endproperty
    a_bus_width: assert property (p_bus_width) else $error("bus width not loaded");

    property p_pause_send;
        (txctl[`HQC_TX_PAUSE_BIT] && SW_FLOW_EN && RX_FIFO_THRESH) |=> TX_PAUSE_SEND;
    endproperty
    a_pause_send: assert property (p_pause_send) else $error("pause not sent");

    property p_tx_drain;
        (tx_state == HQC_RUNNING && !txctl[`HQC_TX_RUN_BIT] && tx_busy && !TX_EVT.done)
        |=> (tx_state == HQC_DRAINING) ##1 TX_RUN;
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("transmit stopped early");

    property p_last_id;
        // rdata follows the address, so only a status read must show the id
        TX_EVT.done |=> (last_id == $past(TX_EVT.id)) ##1 (rdata[5:0] == last_id
                        || bank != `HQC_BANK_QUEUE || idx != `HQC_IDX_TXSTAT);
    endproperty
    a_last_id: assert property (p_last_id) else $error("frame id not kept");

    property p_pause_ignored;
        (PAUSE_RCVD && !rxctl[`HQC_RX_PAUSE_BIT] && !pause_hold) |=> !pause_hold;
    endproperty
    a_pause_ignored: assert property (p_pause_ignored) else $error("pause honoured");

    property p_bad_crc;
        (RX_DESC.valid && RX_DESC.crc_err && !rxctl[`HQC_RX_BADCRC_BIT]) |=> RX_DROP && !RX_ACCEPT;
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad crc admitted");

    property p_promisc;
        (RX_DESC.valid && rx_state == HQC_RUNNING && rxctl[`HQC_RX_PROMISC_BIT]
         && !RX_DESC.crc_err) |=> RX_ACCEPT;
    endproperty
    a_promisc: assert property (p_promisc) else $error("promiscuous frame lost");

    property p_soft_reset;
        // bank select stays writable while the soft reset is held
        (grst && !(wr && idx == `HQC_IDX_BANKSEL))
        |=> (txctl == 16'h0000) && (rxctl == 16'h0000) && (bank == $past(bank));
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    c_accept:  cover property (RX_DESC.valid ##1 RX_ACCEPT);
    c_drain:   cover property (tx_state == HQC_DRAINING ##[1:50] tx_state == HQC_STOPPED);
    c_pause:   cover property (PAUSE_RCVD && rxctl[`HQC_RX_PAUSE_BIT] ##1 !TX_GO);

endmodule : hqc_ctrl

// ==== src/hqc_consts.svh ====
// register indices, field positions, reset values and timing counts of the
// host queue control block; included by the package and the design module.
`ifndef HQC_CONSTS_SVH
`define HQC_CONSTS_SVH

// register indices; byte address is four times the index
`define HQC_IDX_TXCTL      4'h0
`define HQC_IDX_TXSTAT     4'h2
`define HQC_IDX_RXCTL      4'h4
`define HQC_IDX_GRST       4'h6
`define HQC_IDX_BUSCFG     4'h8
`define HQC_IDX_BANKSEL    4'hE

`define HQC_BANK_SYS       5'h03
`define HQC_BANK_QUEUE     5'h10

// transmit control fields
`define HQC_TX_RUN_BIT     0
`define HQC_TX_CRC_BIT     1
`define HQC_TX_PAD_BIT     2
`define HQC_TX_PAUSE_BIT   3
`define HQC_TXCTL_MASK     16'h000F

// receive control fields
`define HQC_RX_RUN_BIT     0
`define HQC_RX_HASH_BIT    2
`define HQC_RX_STRIP_BIT   3
`define HQC_RX_PROMISC_BIT 4
`define HQC_RX_UCAST_BIT   5
`define HQC_RX_MCAST_BIT   6
`define HQC_RX_BCAST_BIT   7
`define HQC_RX_BADCRC_BIT  9
`define HQC_RX_PAUSE_BIT   10
`define HQC_RXCTL_MASK     16'h06FD

`define HQC_CTL_RESET      16'h0000
`define HQC_BANK_RESET     5'h00
`define HQC_MIN_FRAME      7'h40

// one pause quantum is 512 bit times at 100 Mb/s
`define HQC_CLK_NS         25
`define HQC_QUANTUM_NS     5120
`define HQC_QUANTUM_CYC    ((`HQC_QUANTUM_NS + `HQC_CLK_NS - 1) / `HQC_CLK_NS)

`endif

// ==== src/hqc_pkg.sv ====
// types shared by the host queue control block
// assumes hqc_consts.svh is on the include path
package hqc_pkg;
    `include "hqc_consts.svh"

    typedef enum logic [2:0] {
        HQC_STOPPED  = 3'b001,
        HQC_RUNNING  = 3'b010,
        HQC_DRAINING = 3'b100
    } hqc_run_t;

    // one received frame, offered once its header and crc check are known
    typedef struct packed {
        logic        valid;
        logic [47:0] dest;
        logic        crc_err;
        logic        hash_hit;
    } hqc_rx_desc_t;

    // transmit events from the fabric
    typedef struct packed {
        logic        start;
        logic        short_len;
        logic        done;
        logic [5:0]  id;
    } hqc_tx_evt_t;
endpackage : hqc_pkg

// ==== tb/hqc_host_model.sv ====
// host processor model: classic wishbone master for the control registers
// assumes the slave acks within 50 cycles; a missing ack is counted in hang
module hqc_host_model
(
    input  wire logic        clk,   // bus clock
    input  wire logic        ack,   // slave acknowledge
    input  wire logic [31:0] rdata, // slave read data
    output logic             cyc,   // cycle
    output logic             stb,   // strobe
    output logic             we,    // write
    output logic [5:0]       adr,   // byte address
    output logic [3:0]       sel,   // byte lanes
    output logic [31:0]      wdata  // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    int hang = 0;
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        wdata = 32'h0000_0000;
    end
    // request is held until ack is seen high at a rising edge, then dropped
    task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdata <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            hang++;
        q = rdata[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer
endmodule : hqc_host_model

// ==== tb/host_queue_txrx_control_test.sv ====
// self-checking bench for the host queue control block
// assumes hqc_ctrl, hqc_pkg and hqc_host_model; short pause quantum of 2 cycles
module host_queue_txrx_control_test import hqc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] ctl;
        logic [47:0] dest;
        logic        bad;
        logic        hit;
        logic        acc;
    } hqc_row_t;
    localparam logic [47:0] own_a = 48'h0200_0000_0001;
    localparam logic [47:0] oth_a = 48'h0200_0000_0002;
    localparam logic [47:0] bc_a = 48'hFFFF_FFFF_FFFF;
    localparam logic [47:0] mc_a = 48'h0100_5E00_0001;
    logic clk = 1'b0, rst_n = 1'b0, cyc, stb, we, ack, cfg_en = 1'b1, cfg_vld = 1'b0;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] cfg_word = 16'h0000, quanta = 16'h0003, q;
    logic sw_flow = 1'b0, thresh = 1'b0, rx_start = 1'b0, pause_rcvd = 1'b0;
    hqc_tx_evt_t tx_evt = '0;
    hqc_rx_desc_t rx_desc = '0;
    logic tx_run, tx_go, tx_pad, tx_crc, tx_pause, rx_run, rx_acc, rx_drop, rx_strip, qm_rst;
    int error_cnt = 0, n_compared = 0;
    hqc_row_t rows [13] = '{
        '{16'h0009, own_a, 1'b0, 1'b0, 1'b0},
        '{16'h0021, own_a, 1'b0, 1'b0, 1'b1},
        '{16'h0021, oth_a, 1'b0, 1'b0, 1'b0},
        '{16'h0081, bc_a, 1'b0, 1'b0, 1'b1},
        '{16'h0041, bc_a, 1'b0, 1'b0, 1'b1},
        '{16'h0041, mc_a, 1'b0, 1'b0, 1'b1},
        '{16'h0005, mc_a, 1'b0, 1'b1, 1'b1},
        '{16'h0005, mc_a, 1'b0, 1'b0, 1'b0},
        '{16'h0011, oth_a, 1'b0, 1'b0, 1'b1},
        '{16'h0011, oth_a, 1'b1, 1'b0, 1'b0},
        '{16'h0211, oth_a, 1'b1, 1'b0, 1'b1},
        '{16'h00A1, bc_a, 1'b0, 1'b0, 1'b1},
        '{16'h0010, oth_a, 1'b0, 1'b0, 1'b0}};
    always #12.5 clk = ~clk;
    hqc_host_model host (.clk(clk), .ack(ack), .rdata(rdat), .cyc(cyc), .stb(stb), .we(we),
                         .adr(adr), .sel(sel), .wdata(wdat));
    hqc_ctrl #(.QUANTUM_CYC(2)) DUT (
        .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .CONFIG_MEM_EN(cfg_en),
        .CFG_WORD_VALID(cfg_vld), .CFG_WORD(cfg_word), .SW_FLOW_EN(sw_flow),
        .RX_FIFO_THRESH(thresh), .TX_EVT(tx_evt), .RX_START(rx_start), .RX_DESC(rx_desc),
        .PAUSE_RCVD(pause_rcvd), .PAUSE_QUANTA(quanta), .STATION_ADDR(own_a),
        .TX_RUN(tx_run), .TX_GO(tx_go), .TX_PAD(tx_pad), .TX_CRC(tx_crc),
        .TX_PAUSE_SEND(tx_pause), .RX_RUN(rx_run), .RX_ACCEPT(rx_acc), .RX_DROP(rx_drop),
        .RX_STRIP(rx_strip), .QM_RESET(qm_rst));
    task automatic end_of_test();
        error_cnt += host.hang;
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] x;
        host.xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] x;
        host.xfer(1'b0, a, 16'h0000, x);
        chk(x, exp);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    // one-cycle transmit event from the fabric
    task automatic tx_ev(input logic s, input logic sh, input logic d, input logic [5:0] id);
        @(posedge clk);
        tx_evt <= '{s, sh, d, id};
        @(posedge clk);
        tx_evt <= '0;
    endtask : tx_ev
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        chk({6'h00, tx_run, tx_go, tx_pad, tx_crc, tx_pause, rx_run, rx_acc, rx_drop,
             rx_strip, qm_rst}, 16'h0000);
        wr(6'h38, 16'h0010);
        rdc(6'h00, 16'h0000);
        rdc(6'h08, 16'h0000);
        rdc(6'h10, 16'h0000);
        foreach (rows[i])
        begin
            wr(6'h10, rows[i].ctl);
            repeat (3) @(posedge clk);
            rx_desc <= '{1'b1, rows[i].dest, rows[i].bad, rows[i].hit};
            @(posedge clk);
            rx_desc.valid <= 1'b0;
            @(negedge clk);
            chk({rx_acc, rx_drop}, {rows[i].acc, !rows[i].acc});
            chk({rx_strip, rx_run}, {rows[i].ctl[3], rows[i].ctl[0]});
        end
        // receive disabled mid-frame: the frame still completes
        wr(6'h10, 16'h0011);
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        wr(6'h10, 16'h0010);
        settle(3);
        chk(rx_run, 1'b1);
        @(posedge clk);
        rx_desc <= '{1'b1, bc_a, 1'b0, 1'b0};
        @(posedge clk);
        rx_desc.valid <= 1'b0;
        @(negedge clk);
        chk({rx_acc, rx_run}, 2'b11);
        settle(2);
        chk(rx_run, 1'b0);
        // padding is applied to short frames only, not to full-length ones
        wr(6'h00, 16'h0007);
        tx_ev(1'b1, 1'b1, 1'b0, 6'h00);
        settle(0);
        chk({tx_pad, tx_crc, tx_run}, 3'b111);
        tx_ev(1'b0, 1'b0, 1'b1, 6'h2A);
        rdc(6'h08, 16'h002A);
        tx_ev(1'b1, 1'b0, 1'b0, 6'h00);
        settle(0);
        chk(tx_pad, 1'b0);
        wr(6'h00, 16'h0006);
        settle(4);
        chk(tx_run, 1'b1);
        tx_ev(1'b0, 1'b0, 1'b1, 6'h3F);
        settle(3);
        chk({tx_run, tx_crc}, 2'b01);
        rdc(6'h08, 16'h003F);
        wr(6'h00, 16'h0009);
        sw_flow <= 1'b1;
        thresh <= 1'b1;
        settle(3);
        chk({tx_pause, tx_crc}, 2'b10);
        @(posedge clk);
        sw_flow <= 1'b0;
        settle(3);
        chk(tx_pause, 1'b0);
        wr(6'h10, 16'h0400);
        settle(3);
        chk(tx_go, 1'b1);
        @(posedge clk);
        pause_rcvd <= 1'b1;
        @(posedge clk);
        pause_rcvd <= 1'b0;
        settle(3);
        chk(tx_go, 1'b0);
        settle(10);
        chk(tx_go, 1'b1);
        wr(6'h10, 16'h0000);
        pause_rcvd <= 1'b1;
        @(posedge clk);
        pause_rcvd <= 1'b0;
        settle(3);
        chk(tx_go, 1'b1);
        wr(6'h38, 16'h0003);
        cfg_word <= 16'hFFFF;
        cfg_vld <= 1'b1;
        @(posedge clk);
        cfg_vld <= 1'b0;
        rdc(6'h20, 16'h0001);
        cfg_word <= 16'hFFFE;
        cfg_vld <= 1'b1;
        @(posedge clk);
        cfg_vld <= 1'b0;
        rdc(6'h20, 16'h0000);
        cfg_word <= 16'hFFFF;
        cfg_vld <= 1'b1;
        @(posedge clk);
        cfg_vld <= 1'b0;
        cfg_en <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(6'h20, 16'h0000);
        wr(6'h38, 16'h0005);
        wr(6'h00, 16'h000F);
        rdc(6'h00, 16'h0000);
        rdc(6'h38, 16'h0005);
        wr(6'h38, 16'h0010);
        rdc(6'h00, 16'h0009);
        wr(6'h38, 16'h0003);
        wr(6'h18, 16'h0001);
        settle(2);
        chk(qm_rst, 1'b1);
        wr(6'h38, 16'h0010);
        rdc(6'h00, 16'h0000);
        rdc(6'h38, 16'h0010);
        // hard reset in mid-run clears the soft reset and the bank select
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        chk({tx_run, tx_go, tx_pause, rx_run, qm_rst}, 5'h00);
        rdc(6'h38, 16'h0000);
        end_of_test();
    end
endmodule : host_queue_txrx_control_test
